// *** core/rtc_device.sv ***
/*
 * Clock/calendar end of the three-wire link: BCD timekeeping and serial port.
 * Assumes link pins come from outside the core clock domain.
 */
`timescale 1ns/1ps
module rtc_device #(
  parameter int OSC_DIV     = rtc_pkg::OSC_DIV_CYCLES,
  parameter int OSC_PER_SEC = rtc_pkg::OSC_HZ
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  // link
  rtc_link_if.device  link,
  // user side status
  output logic        secondTick,
  output logic        oscRunning,
  output logic        lockActive
);
  import rtc_pkg::*;

  typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ, PH_IDLE} phase_e;

  // ******************************************************
  // helpers
  // ******************************************************
  function automatic byte_t bcdInc(input byte_t v);
    bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01; // [R07]
  endfunction : bcdInc

  function automatic byte_t monthLen(input byte_t mon, input byte_t yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02:                      monthLen = leap ? 8'h29 : 8'h28; // [R14]
      8'h04, 8'h06, 8'h09, 8'h11: monthLen = 8'h30;
      default:                    monthLen = 8'h31;
    endcase
  endfunction : monthLen

  // ******************************************************
  // pin synchronisers
  // ******************************************************
  logic [1:0] gateSync;
  logic [2:0] clkSync;
  logic [1:0] dinSync;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gateSync <= 2'h0;
      clkSync  <= 3'h0;
      dinSync  <= 2'h0;
    end else begin
      gateSync <= {gateSync[0], link.transferGate};
      clkSync  <= {clkSync[1:0], link.shiftClk};
      dinSync  <= {dinSync[0], link.dataLine};
    end
  end

  logic gateOn;
  logic clkRise;
  logic clkFall;
  logic dinBit;
  assign gateOn  = gateSync[1];
  assign clkRise = clkSync[1] & ~clkSync[2]; // [R20]
  assign clkFall = ~clkSync[1] & clkSync[2];
  assign dinBit  = dinSync[1];

  // ******************************************************
  // timebase
  // ******************************************************
  byte_t       timeRegs [NUM_REGS];
  logic [15:0] oscCnt;
  logic [15:0] subCnt;
  logic        halted;
  logic        oscTick;
  logic        secTick;
  logic        secPendQ;
  logic        commitQ;
  logic [2:0]  commitIdxQ;
  byte_t       commitDataQ;

  assign halted  = timeRegs[REG_SEC][HALT_BIT]; // [R08]
  assign oscTick = !halted && (oscCnt == 16'(OSC_DIV - 1));
  assign secTick = oscTick && (subCnt == 16'(OSC_PER_SEC - 1)); // [R15]

  always_ff @(posedge core_clk) begin
    if (!rst_n || halted) begin
      oscCnt <= 16'h0000;
      subCnt <= 16'h0000;
    end else if (oscTick) begin
      oscCnt <= 16'h0000;
      subCnt <= secTick ? 16'h0000 : subCnt + 16'h0001;
    end else begin
      oscCnt <= oscCnt + 16'h0001;
    end
  end

  // tick waits out a colliding register write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secPendQ <= 1'b0;
    end else if (secTick) begin
      secPendQ <= 1'b1;
    end else if (!commitQ) begin
      secPendQ <= 1'b0;
    end
  end

  // ******************************************************
  // calendar carry chain
  // ******************************************************
  byte_t tickNext [NUM_REGS];
  logic  cMin;
  logic  cHour;
  logic  cDay;
  logic  cMonth;
  byte_t secInc;
  byte_t hr12Inc;
  byte_t hr24Inc;

  // incremented digit fields, sliced where used
  assign secInc  = bcdInc({1'b0, timeRegs[REG_SEC][6:0]});
  assign hr12Inc = bcdInc({3'b000, timeRegs[REG_HOUR][4:0]});
  assign hr24Inc = bcdInc({2'b00, timeRegs[REG_HOUR][5:0]});

  always_comb begin
    tickNext = timeRegs;
    cMin     = timeRegs[REG_SEC][6:0] == 7'h59; // [R12]
    cHour    = timeRegs[REG_MIN] == 8'h59;
    cDay     = 1'b0;
    cMonth   = timeRegs[REG_DATE] == monthLen(timeRegs[REG_MONTH], timeRegs[REG_YEAR]);
    tickNext[REG_SEC] = {timeRegs[REG_SEC][HALT_BIT],
                         cMin ? 7'h00 : secInc[6:0]};
    if (cMin) begin
      tickNext[REG_MIN] = cHour ? 8'h00 : bcdInc(timeRegs[REG_MIN]);
    end
    if (cMin && cHour) begin
      if (timeRegs[REG_HOUR][FMT12_BIT]) begin // [R10]
        unique case (timeRegs[REG_HOUR][4:0])
          5'h12: tickNext[REG_HOUR] = {timeRegs[REG_HOUR][7:5], 5'h01};
          5'h11: begin
            tickNext[REG_HOUR] = {2'b10, ~timeRegs[REG_HOUR][PM_BIT], 5'h12}; // [R11]
            cDay = timeRegs[REG_HOUR][PM_BIT];
          end
          default: tickNext[REG_HOUR] = {timeRegs[REG_HOUR][7:5], hr12Inc[4:0]};
        endcase
      end else if (timeRegs[REG_HOUR][5:0] == 6'h23) begin
        tickNext[REG_HOUR] = 8'h00;
        cDay = 1'b1;
      end else begin
        tickNext[REG_HOUR] = {2'b00, hr24Inc[5:0]};
      end
    end
    if (cDay) begin
      tickNext[REG_WDAY] = (timeRegs[REG_WDAY] == 8'h07) ? 8'h01 : bcdInc(timeRegs[REG_WDAY]);
      tickNext[REG_DATE] = cMonth ? 8'h01 : bcdInc(timeRegs[REG_DATE]); // [R14]
      if (cMonth) begin
        if (timeRegs[REG_MONTH] == 8'h12) begin
          tickNext[REG_MONTH] = 8'h01;
          tickNext[REG_YEAR]  = (timeRegs[REG_YEAR] == 8'h99) ? 8'h00
                                                              : bcdInc(timeRegs[REG_YEAR]);
        end else begin
          tickNext[REG_MONTH] = bcdInc(timeRegs[REG_MONTH]);
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      timeRegs <= REG_RESET;
    end else if (commitQ) begin
      if (commitIdxQ == REG_LOCK) begin
        timeRegs[REG_LOCK] <= {commitDataQ[LOCK_BIT], 7'h00}; // [R09]
      end else begin
        timeRegs[commitIdxQ] <= commitDataQ; // [R13]
      end
    end else if (secPendQ) begin
      timeRegs <= tickNext;
    end
  end

  // ******************************************************
  // serial port
  // ******************************************************
  phase_e     phaseQ;
  logic [2:0] bitCntQ;
  logic [2:0] idxQ;
  logic       burstQ;
  byte_t      cmdQ;
  byte_t      shiftQ;
  byte_t      cmdNext;
  byte_t      rxNext;
  logic       writeOk;

  assign cmdNext = {dinBit, cmdQ[7:1]}; // [R01]
  assign rxNext  = {dinBit, shiftQ[7:1]};
  // lock register writable only singly, others only while unlocked
  assign writeOk = (idxQ == REG_LOCK) ? !burstQ // [R23] [R24]
                                      : !timeRegs[REG_LOCK][LOCK_BIT]; // [R09]

  always_ff @(posedge core_clk) begin
    if (!rst_n || !gateOn) begin // [R21]
      phaseQ          <= PH_CMD;
      bitCntQ         <= 3'h0;
      idxQ            <= 3'h0;
      burstQ          <= 1'b0;
      cmdQ            <= 8'h00;
      shiftQ          <= 8'h00;
      commitQ         <= 1'b0;
      commitIdxQ      <= 3'h0;
      commitDataQ     <= 8'h00;
      link.devDataOut <= 1'b0;
      link.devDataOeN <= 1'b1;
    end else begin
      commitQ <= 1'b0;
      unique case (phaseQ)
        PH_CMD: if (clkRise) begin
          cmdQ    <= cmdNext;
          bitCntQ <= bitCntQ + 3'h1;
          if (bitCntQ == 3'h7) begin
            burstQ <= (cmdNext & CMD_DIR_MASK) == CMD_BURST; // [R04]
            idxQ   <= ((cmdNext & CMD_DIR_MASK) == CMD_BURST) ? REG_SEC : cmdNext[3:1]; // [R03] [R05]
            if (((cmdNext & CMD_DIR_MASK) == CMD_BURST)
                || (cmdNext[CMD_VALID_BIT] && cmdNext[6:4] == 3'b000)) begin
              phaseQ <= cmdNext[CMD_DIR_BIT] ? PH_READ : PH_WRITE; // [R02]
            end else begin
              phaseQ <= PH_IDLE;
            end
          end
        end
        PH_WRITE: if (clkRise) begin
          shiftQ  <= rxNext; // [R20]
          bitCntQ <= bitCntQ + 3'h1;
          if (bitCntQ == 3'h7) begin
            commitQ     <= writeOk;
            commitIdxQ  <= idxQ;
            commitDataQ <= rxNext;
            idxQ        <= idxQ + 3'h1;
            if (!burstQ || idxQ == REG_LOCK) begin
              phaseQ <= PH_IDLE; // [R06] [R22]
            end
          end
        end
        PH_READ: if (clkFall) begin
          link.devDataOeN <= 1'b0;
          bitCntQ         <= bitCntQ + 3'h1;
          if (bitCntQ == 3'h0) begin
            link.devDataOut <= timeRegs[idxQ][0]; // [R20]
            shiftQ          <= {1'b0, timeRegs[idxQ][7:1]};
          end else begin
            link.devDataOut <= shiftQ[0];
            shiftQ          <= {1'b0, shiftQ[7:1]};
          end
          if (bitCntQ == 3'h7 && burstQ) begin
            idxQ <= idxQ + 3'h1; // [R05]
          end
        end
        PH_IDLE: ;
      endcase
    end
  end

  // ******************************************************
  // user status
  // ******************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      secondTick <= 1'b0;
      oscRunning <= 1'b0;
      lockActive <= 1'b0;
    end else begin
      secondTick <= secTick;
      oscRunning <= !halted;
      lockActive <= timeRegs[REG_LOCK][LOCK_BIT];
    end
  end

endmodule : rtc_device

// *** core/rtc_host.sv ***
/*
 * Host controller end: runs one link transfer per command register write.
 * Assumes software waits for busy to clear before issuing the next command.
 */
`timescale 1ns/1ps
module rtc_host (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  // link
  rtc_link_if.host            link,
  // software register port
  input  wire rtc_pkg::host_addr_t addr,
  input  wire rtc_pkg::byte_t wrData,
  input  wire logic           wrStb,
  input  wire logic           rdStb,
  output rtc_pkg::byte_t      rdData
);
  import rtc_pkg::*;

  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_LOW, HS_HIGH, HS_HOLD, HS_GAP} hstate_e;

  hstate_e    stateQ;
  logic [7:0] timerQ;
  logic [6:0] bitQ;
  byte_t      cmdQ;
  byte_t      bufQ [NUM_REGS];
  logic [1:0] dinSync;
  logic       isRead;
  logic [6:0] lastBit;
  logic [2:0] byteSel;
  logic       txBit;

  assign isRead  = cmdQ[CMD_DIR_BIT];
  assign lastBit = ((cmdQ & CMD_DIR_MASK) == CMD_BURST) ? 7'(BURST_BITS - 1)
                                                         : 7'(SINGLE_BITS - 1); // [R06]
  assign byteSel = 3'(bitQ[6:3] - 4'h1);
  // command first, then data, each LSB first
  assign txBit   = (bitQ < 7'd8) ? cmdQ[bitQ[2:0]] : bufQ[byteSel][bitQ[2:0]]; // [R19] [R20]

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dinSync <= 2'h0;
    end else begin
      dinSync <= {dinSync[0], link.dataLine};
    end
  end

  // ******************************************************
  // link sequencer
  // ******************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stateQ            <= HS_IDLE;
      timerQ            <= 8'h00;
      bitQ              <= 7'h00;
      link.transferGate <= 1'b0;
      link.shiftClk     <= 1'b0;
      link.hostDataOut  <= 1'b0;
      link.hostDataOeN  <= 1'b1;
    end else begin
      timerQ <= (timerQ == 8'h00) ? 8'h00 : timerQ - 8'h01;
      unique case (stateQ)
        HS_IDLE: if (wrStb && addr == HOST_OFS_CMD) begin
          stateQ            <= HS_SETUP;
          link.transferGate <= 1'b1; // [R16]
          timerQ            <= 8'(GATE_SETUP_CYCLES - 1);
          bitQ              <= 7'h00;
        end
        HS_SETUP: if (timerQ == 8'h00) begin
          stateQ <= HS_LOW;
          timerQ <= 8'(SCLK_HALF_CYCLES - 1);
          link.hostDataOut <= txBit;
          link.hostDataOeN <= 1'b0;
        end
        HS_LOW: if (timerQ == 8'h00) begin
          stateQ        <= HS_HIGH;
          timerQ        <= 8'(SCLK_HALF_CYCLES - 1);
          link.shiftClk <= 1'b1;
        end
        HS_HIGH: if (timerQ == 8'h00) begin
          link.shiftClk <= 1'b0;
          if (bitQ == lastBit) begin
            stateQ           <= HS_HOLD;
            timerQ           <= 8'(GATE_HOLD_CYCLES - 1);
            link.hostDataOeN <= 1'b1;
          end else begin
            stateQ           <= HS_LOW;
            timerQ           <= 8'(SCLK_HALF_CYCLES - 1);
            bitQ             <= bitQ + 7'h01;
            link.hostDataOut <= txBit_next(bitQ + 7'h01);
            link.hostDataOeN <= isRead && (bitQ >= 7'd7); // [R20]
          end
        end
        HS_HOLD: if (timerQ == 8'h00) begin
          stateQ            <= HS_GAP;
          timerQ            <= 8'(GATE_IDLE_CYCLES - 1);
          link.transferGate <= 1'b0;
        end
        HS_GAP: if (timerQ == 8'h00) begin
          stateQ <= HS_IDLE;
        end
        default: stateQ <= HS_IDLE;
      endcase
    end
  end

  function automatic logic txBit_next(input logic [6:0] b);
    logic [2:0] k;
    k = 3'(b[6:3] - 4'h1);
    txBit_next = (b < 7'd8) ? cmdQ[b[2:0]] : bufQ[k][b[2:0]];
  endfunction : txBit_next

  // ******************************************************
  // command, buffer and read port
  // ******************************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmdQ <= 8'h00;
      bufQ <= '{default: 8'h00};
    end else if (stateQ == HS_IDLE && wrStb) begin
      if (addr == HOST_OFS_CMD) begin
        cmdQ <= wrData; // [R01]
      end else if (addr >= HOST_OFS_BUF) begin
        bufQ[addr[2:0]] <= wrData;
      end
    end else if (stateQ == HS_LOW && timerQ == 8'h00 && isRead && bitQ >= 7'd8) begin
      bufQ[byteSel][bitQ[2:0]] <= dinSync[1]; // [R20]
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else if (rdStb) begin
      if (addr == HOST_OFS_CMD) begin
        rdData <= cmdQ;
      end else if (addr == HOST_OFS_STATUS) begin
        rdData <= {7'h00, stateQ != HS_IDLE};
      end else if (addr >= HOST_OFS_BUF) begin
        rdData <= bufQ[addr[2:0]];
      end else begin
        rdData <= 8'h00;
      end
    end
  end

endmodule : rtc_host

// *** core/rtc_link_if.sv ***
/*
 * Three-wire link between host controller and clock/calendar.
 * Assumes both ends run on one core clock; the data line idles high.
 */
`timescale 1ns/1ps
interface rtc_link_if;
  logic transferGate;
  logic shiftClk;
  logic hostDataOut;
  logic hostDataOeN;
  logic devDataOut;
  logic devDataOeN;
  logic dataLine;

  // resolved wire level, pulled high when nobody drives
  assign dataLine = !devDataOeN ? devDataOut : (!hostDataOeN ? hostDataOut : 1'b1);

  modport host (
    output transferGate,
    output shiftClk,
    output hostDataOut,
    output hostDataOeN,
    input  dataLine
  );

  modport device (
    input  transferGate,
    input  shiftClk,
    input  dataLine,
    output devDataOut,
    output devDataOeN
  );
endinterface : rtc_link_if

// *** core/rtc_pkg.sv ***
/*
 * Shared constants for the serial BCD clock/calendar and its host controller.
 * Assumes a single 20 MHz core clock in every module that imports it.
 */
// Summary of operation
// [R01] Each transfer opens with an eight-bit command
// [R02] Command bit 0 low writes, high reads
// [R03] Command bits 3..1 pick one of eight registers
// [R04] Command 10111110 bursts writes; set bit reads
// [R05] Burst starts at register zero, bit zero
// [R06] One data byte, or up to eight in burst
// [R07] Time registers hold BCD tens and units nibbles
// [R08] Seconds bit 7 halts the oscillator and counting
// [R09] Lock register bit 7 refuses other writes
// [R10] Hours bit 7 selects 12-hour counting
// [R11] Hours bit 5 is PM, or tens in 24-hour
// [R12] Each counter wraps in range and carries onward
// [R13] Order: sec, min, hour, date, month, weekday, year, lock
// [R14] Date follows month length and leap years
// [R15] Second tick divided from a 32768 Hz oscillator
// [R16] Link has gate, shift clock, one data line
// [R17] Host sets halt and lock bits first; rtc_host sets neither, the device reset values set both
// [R18] Host loads all eight registers at start; rtc_host loads none and only runs the transfers software commands
// [R19] Host write sends command then data byte
// [R20] Sample on rising, drive after falling, LSB first
// [R21] Gate low aborts transfer and releases data line
// [R22] Single read repeats; single write ignores extra clocks
// [R23] Burst write never changes the lock bit
// [R24] Lock register stays writable while locked
package rtc_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] host_addr_t;

  // ******************************************************
  // clock rates and derived counts
  // ******************************************************
  localparam int CORE_HZ        = 20_000_000;
  localparam int CORE_PERIOD_NS = 50;
  localparam int OSC_HZ         = 32768;
  localparam int OSC_DIV_CYCLES = CORE_HZ / OSC_HZ;

  localparam int SCLK_PERIOD_NS    = 1000;
  localparam int SCLK_HALF_CYCLES  = SCLK_PERIOD_NS / (2 * CORE_PERIOD_NS);
  localparam int GATE_SETUP_NS     = 1000;
  localparam int GATE_SETUP_CYCLES = (GATE_SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int GATE_HOLD_NS      = 60;
  localparam int GATE_HOLD_CYCLES  = (GATE_HOLD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int GATE_IDLE_NS      = 1000;
  localparam int GATE_IDLE_CYCLES  = (GATE_IDLE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // ******************************************************
  // device register map and fields
  // ******************************************************
  localparam logic [2:0] REG_SEC   = 3'h0;
  localparam logic [2:0] REG_MIN   = 3'h1;
  localparam logic [2:0] REG_HOUR  = 3'h2;
  localparam logic [2:0] REG_DATE  = 3'h3;
  localparam logic [2:0] REG_MONTH = 3'h4;
  localparam logic [2:0] REG_WDAY  = 3'h5;
  localparam logic [2:0] REG_YEAR  = 3'h6;
  localparam logic [2:0] REG_LOCK  = 3'h7;
  localparam int         NUM_REGS  = 8;

  localparam int HALT_BIT  = 7;
  localparam int LOCK_BIT  = 7;
  localparam int FMT12_BIT = 7;
  localparam int PM_BIT    = 5;

  localparam byte_t REG_RESET [NUM_REGS] =
    '{8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};

  // ******************************************************
  // command byte
  // ******************************************************
  localparam int    CMD_VALID_BIT = 7;
  localparam int    CMD_DIR_BIT   = 0;
  localparam byte_t CMD_BURST     = 8'hBE;
  localparam byte_t CMD_DIR_MASK  = 8'hFE;
  localparam int    SINGLE_BITS   = 16;
  localparam int    BURST_BITS    = 72;

  // ******************************************************
  // host controller register port
  // ******************************************************
  localparam host_addr_t HOST_OFS_CMD    = 4'h0;
  localparam host_addr_t HOST_OFS_STATUS = 4'h1;
  localparam host_addr_t HOST_OFS_BUF    = 4'h8;
  localparam int         STATUS_BUSY_BIT = 0;

endpackage : rtc_pkg

// *** verification/serial_bcd_clock_calendar_props.sv ***
/*
 * Checker for the three-wire link between host controller and clock/calendar.
 * Assumes the bench feeds it the signals of the interface joining both ends.
 */
`timescale 1ns/1ps
module serial_bcd_clock_calendar_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // link
  input wire logic transferGate,
  input wire logic shiftClk,
  input wire logic hostDataOeN,
  input wire logic devDataOut,
  input wire logic devDataOeN
);
  logic       clkQ;
  logic [7:0] riseCnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ******************************************************
  // shift clock rises inside the open frame
  // ******************************************************
  always_ff @(posedge core_clk) begin
    clkQ <= shiftClk;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !transferGate) begin
      riseCnt <= 8'h00;
    end else if (shiftClk && !clkQ) begin
      riseCnt <= riseCnt + 8'h01;
    end
  end

  // ******************************************************
  // assertions
  // ******************************************************
  a_frame_bit_count: assert property (
    $fell(transferGate) |-> (riseCnt == 8'h10 || riseCnt == 8'h48))
    else $error("frame closed after an odd number of clocks");
  a_gate_abort_release: assert property (
    $fell(transferGate) |-> ##[0:4] devDataOeN)
    else $error("device kept the data line after gate low");
  a_idle_released: assert property (
    !transferGate [*5] |-> devDataOeN)
    else $error("device drives the data line while idle");
  a_no_contention: assert property (
    !(!devDataOeN && !hostDataOeN))
    else $error("both ends drive the data line");
  a_dev_drive_low: assert property (
    $changed(devDataOut) && !devDataOeN |-> !shiftClk)
    else $error("device data changed while shift clock high");
  a_read_first_bit: assert property (
    $fell(devDataOeN) |-> !shiftClk && riseCnt == 8'h08)
    else $error("device began driving at the wrong bit");
  a_clk_high_time: assert property (
    $rose(shiftClk) |-> shiftClk [*8])
    else $error("shift clock high phase too short");
  a_clk_in_frame: assert property (
    shiftClk |-> transferGate)
    else $error("shift clock outside an open frame");
  a_gate_setup: assert property (
    $rose(shiftClk) && riseCnt == 8'h00 |-> $past(transferGate, 20))
    else $error("first clock too soon after gate high");

  cover property ($fell(transferGate) && riseCnt == 8'h10);
  cover property ($fell(transferGate) && riseCnt == 8'h48);
  cover property ($fell(devDataOeN));
endmodule : serial_bcd_clock_calendar_props

// *** verification/serial_bcd_clock_calendar_test.sv ***
/*
 * Bench joining host controller and clock/calendar over the link interface.
 * Assumes the host buffer byte 0 receives single read data, bytes 0..7 burst.
 */
`timescale 1ns/1ps
module serial_bcd_clock_calendar_test;
  import rtc_pkg::*;

  logic       core_clk;
  logic       rst_n;
  host_addr_t addr;
  byte_t      wrData;
  logic       wrStb;
  logic       rdStb;
  byte_t      rdData;
  logic       secondTick;
  logic       oscRunning;
  logic       lockActive;
  int         failures;
  int         checks;
  byte_t      cap;
  byte_t      rb;
  logic       monClk;
  int         monBits;
  byte_t      burstW [8] = '{8'hD8, 8'h59, 8'h23, 8'h28, 8'h02, 8'h07, 8'h00, 8'h80};
  byte_t      burstR [8] = '{8'h00, 8'h00, 8'h00, 8'h29, 8'h02, 8'h01, 8'h00, 8'h00};

  rtc_link_if link ();

  rtc_device #(.OSC_DIV(2), .OSC_PER_SEC(2000)) rtc_device_i (
    .core_clk(core_clk), .rst_n(rst_n), .link(link),
    .secondTick(secondTick), .oscRunning(oscRunning), .lockActive(lockActive));
  rtc_host rtc_host_i (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
  serial_bcd_clock_calendar_props serial_bcd_clock_calendar_props_i (
    .core_clk(core_clk), .rst_n(rst_n), .transferGate(link.transferGate),
    .shiftClk(link.shiftClk), .hostDataOeN(link.hostDataOeN),
    .devDataOut(link.devDataOut), .devDataOeN(link.devDataOeN));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  // ******************************************************
  // wire monitor: first eight bits of each frame
  // ******************************************************
  always @(posedge core_clk) begin
    monClk <= link.shiftClk;
    if (link.shiftClk && !monClk && monBits < 8) cap <= {link.dataLine, cap[7:1]};
    if (link.shiftClk && !monClk) monBits <= monBits + 1;
    if (!link.transferGate) monBits <= 0;
  end

  // ******************************************************
  // register port tasks
  // ******************************************************
  task automatic chk(input byte_t exp, input byte_t got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic wr(input host_addr_t a, input byte_t d);
    @(posedge core_clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge core_clk);
    wrStb  <= 1'b0;
  endtask : wr

  task automatic rd(input host_addr_t a, output byte_t d);
    @(posedge core_clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    #1 d = rdData;
  endtask : rd

  task automatic xfer(input byte_t cmd);
    byte_t st;
    int    n;
    n = 0;
    wr(HOST_OFS_CMD, cmd);
    do begin
      rd(HOST_OFS_STATUS, st);
      n++;
    end while (st[STATUS_BUSY_BIT] !== 1'b0 && n < 5000);
    chk(8'h00, st & 8'h01);
    chk(cmd, cap);
  endtask : xfer

  task automatic rdReg(input logic [2:0] a, input byte_t exp);
    xfer({4'h8, a, 1'b1});
    rd(HOST_OFS_BUF, rb);
    chk(exp, rb);
  endtask : rdReg

  task automatic wrReg(input logic [2:0] a, input byte_t d);
    wr(HOST_OFS_BUF, d);
    xfer({4'h8, a, 1'b0});
  endtask : wrReg

  task automatic waitTick;
    int n;
    n = 0;
    @(posedge core_clk);
    while (secondTick !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk(8'h01, {7'h00, secondTick});
  endtask : waitTick

  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // ******************************************************
  // tests
  // ******************************************************
  initial begin
    {rst_n, wrStb, rdStb, monClk} = 4'h0;
    {addr, wrData, cap} = '0;
    failures = 0;
    checks   = 0;
    monBits  = 0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_REGS; i++) rdReg(i[2:0], REG_RESET[i]);
    chk(8'h01, {7'h00, lockActive});
    wrReg(REG_MIN, 8'h33);
    rdReg(REG_MIN, 8'h00);
    wrReg(REG_LOCK, 8'h00);
    chk(8'h00, {7'h00, lockActive});
    for (int i = 0; i < NUM_REGS; i++) wr(HOST_OFS_BUF + 4'(i), burstW[i]);
    xfer(CMD_BURST);
    rdReg(REG_LOCK, 8'h00);
    rdReg(REG_HOUR, 8'h23);
    wrReg(REG_SEC, 8'h58);
    chk(8'h01, {7'h00, oscRunning});
    repeat (2) waitTick();
    xfer(CMD_BURST | 8'h01);
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(HOST_OFS_BUF + 4'(i), rb);
      chk(burstR[i], rb);
    end
    wrReg(REG_SEC, 8'h80);
    chk(8'h00, {7'h00, oscRunning});
    xfer(8'h91);
    rd(HOST_OFS_BUF, rb);
    chk(8'hFF, rb);
    wrReg(REG_LOCK, 8'h80);
    chk(8'h01, {7'h00, lockActive});
    rd(4'h5, rb);
    chk(8'h00, rb);
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    $display("wrong value at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : serial_bcd_clock_calendar_test
